// ===== src/dcim_ctrl.sv
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Function
// [RL1] Strobe encodings select each command
// [RL2] Clock enable edges enter and exit low power
// [RL3] Device drops masked write bytes
// [RL4] Device bursts four or eight locations
// [RL5] Activate carries bank and row
// [RL6] Column bits, bit ten auto or all precharge
// [RL7] Activate idle banks, access active banks only
// [RL8] Wait 200 us, then raise clock enable
// [RL9] Hold 400 ns no-operation, then precharge all
// [RL10] Write second then third extended register
// [RL11] Enable loop through first extended register
// [RL12] Mode write with loop reset bit set
// [RL13] Precharge all, two refreshes, mode write
// [RL14] Calibration default then exit, after 200 clocks
// [RL15] Clock enable and termination low at power-up
// [RL16] Mode write only precharged, clock enable high
// [RL17] Wait mode command cycle time after writes
// [RL18] Program mode at init, reprogram when precharged
// [RL19] Device takes burst length and order
// [RL20] Read latency field programmed by software
// [RL21] Test and loop-reset bits zero normally
// [RL22] Write recovery field, third bank bit zero
// [RL23] First extended register field layout
// [RL24] Device ignores commands while clock enable low
module dcim_ctrl #(
  parameter int POWERUP_CYC = dcim_pkg::POWERUP_WAIT_CYC,
  parameter int BANKS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory pins
  output dcim_pkg::dcim_pins_type pins
);
  typedef enum {
    S_POWERUP, S_CKE_WAIT, S_PREALL1, S_EMR2, S_EMR3, S_EMR1, S_MR_DLLRST, S_PREALL2,
    S_REF, S_MR_OP, S_CAL_WAIT, S_CAL_DEF, S_CAL_EXIT, S_READY, S_PWRDN, S_GAP
  } dcim_state_type;

  localparam int CNT_W = $clog2(POWERUP_CYC + 1) + 1;

  function automatic logic [3:0] op_enc(input dcim_pkg::dcim_op_type op);
    case (op)
      dcim_pkg::DCIM_OP_ACT: op_enc = dcim_pkg::ENC_ACT;
      dcim_pkg::DCIM_OP_PRE, dcim_pkg::DCIM_OP_PREALL: op_enc = dcim_pkg::ENC_PRE;
      dcim_pkg::DCIM_OP_RD: op_enc = dcim_pkg::ENC_RD;
      dcim_pkg::DCIM_OP_WR: op_enc = dcim_pkg::ENC_WR;
      dcim_pkg::DCIM_OP_REF, dcim_pkg::DCIM_OP_SRE: op_enc = dcim_pkg::ENC_REF;
      dcim_pkg::DCIM_OP_MRS: op_enc = dcim_pkg::ENC_MRS;
      default: op_enc = dcim_pkg::ENC_NOP;
    endcase
  endfunction

  function automatic logic [12:0] mr_word(input logic [12:0] mode, input logic dllrst);
    logic [12:0] w;
    w = mode;
    w[dcim_pkg::MR_TM_BIT] = 1'b0; // [RL21]
    w[dcim_pkg::MR_DLLRST_BIT] = dllrst;
    mr_word = w;
  endfunction

  dcim_state_type state, next_state, resume, next_resume;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [7:0] dll_cnt, next_dll_cnt;
  logic [1:0] ref_cnt, next_ref_cnt;
  logic [3:0] gap, next_gap;
  logic cke_level, next_cke_level;
  logic [BANKS-1:0] open_bank, next_open_bank;
  logic [12:0] mode_reg, next_mode_reg;
  logic [12:0] ext1_reg, next_ext1_reg;
  logic [3:0] tmrd_reg, next_tmrd_reg;
  logic [15:0] addr_reg, next_addr_reg;
  logic [2:0] ba_reg, next_ba_reg;
  logic pend, next_pend;
  dcim_pkg::dcim_op_type pend_op, next_pend_op;
  logic err, next_err;
  logic issue;
  dcim_pkg::dcim_cmd_type cmd;

  // AHB address phase capture
  logic dp_wr, next_dp_wr;
  logic [7:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic ap_valid;

  assign ap_valid = hsel && hready && htrans[1];
  // Zero wait states; the OKAY answer is fixed
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_dp_wr = ap_valid && hwrite;
    next_dp_addr = ap_valid ? haddr[7:0] : dp_addr;
  end

  // Register file and command sequencing
  always_comb begin
    logic [3:0] sw_op;
    logic ok;
    sw_op = 4'h0;
    ok = 1'b0;
    next_state = state;
    next_resume = resume;
    next_cnt = cnt;
    next_dll_cnt = (dll_cnt != 8'hFF) ? dll_cnt + 8'h01 : dll_cnt;
    next_ref_cnt = ref_cnt;
    next_gap = gap;
    next_cke_level = cke_level;
    next_open_bank = open_bank;
    next_mode_reg = mode_reg;
    next_ext1_reg = ext1_reg;
    next_tmrd_reg = tmrd_reg;
    next_addr_reg = addr_reg;
    next_ba_reg = ba_reg;
    next_pend = pend;
    next_pend_op = pend_op;
    next_err = err;
    next_hrdata = hrdata;
    issue = 1'b0;
    cmd = '{enc: dcim_pkg::ENC_NOP, ba: 3'h0, addr: 13'h0000};

    if (dp_wr) begin
      case (dp_addr)
        dcim_pkg::REG_CTRL: if (hwdata[1]) next_err = 1'b0;
        dcim_pkg::REG_MODE: next_mode_reg = hwdata[12:0];
        dcim_pkg::REG_EXT1: next_ext1_reg = hwdata[12:0];
        dcim_pkg::REG_ADDR: begin
          next_addr_reg = hwdata[15:0];
          next_ba_reg = hwdata[18:16];
        end
        dcim_pkg::REG_TMRD: next_tmrd_reg = (hwdata[3:0] == 4'h0) ? 4'h1 : hwdata[3:0];
        dcim_pkg::REG_CMD: if (!pend) begin
          sw_op = hwdata[3:0];
          next_pend = 1'b1;
          next_pend_op = dcim_pkg::dcim_op_type'(sw_op);
        end
        default: ;
      endcase
    end

    case (state)
      S_POWERUP: begin
        next_cke_level = 1'b0; // [RL15]
        if (cnt >= CNT_W'(POWERUP_CYC)) begin // [RL8]
          next_cke_level = 1'b1;
          next_cnt = '0;
          next_state = S_CKE_WAIT;
        end else next_cnt = cnt + 1'b1;
      end
      S_CKE_WAIT: begin
        if (cnt >= CNT_W'(dcim_pkg::CKE_NOP_WAIT_CYC)) next_state = S_PREALL1; // [RL9]
        else next_cnt = cnt + 1'b1;
      end
      S_PREALL1, S_PREALL2: begin
        issue = 1'b1;
        cmd = '{enc: dcim_pkg::ENC_PRE, ba: 3'h0, addr: 13'h0400}; // [RL6] [RL9] [RL13]
        next_open_bank = '0;
        next_ref_cnt = 2'h0;
        next_state = (state == S_PREALL1) ? S_EMR2 : S_REF;
      end
      S_EMR2, S_EMR3, S_EMR1, S_MR_DLLRST, S_MR_OP, S_CAL_DEF, S_CAL_EXIT: begin
        issue = 1'b1;
        cmd.enc = dcim_pkg::ENC_MRS; // [RL16]
        next_gap = tmrd_reg;
        next_state = S_GAP;
        case (state)
          S_EMR2: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_EMR2}; // [RL10]
            next_resume = S_EMR3;
          end
          S_EMR3: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_EMR3}; // [RL10]
            next_resume = S_EMR1;
          end
          S_EMR1: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_EMR1};
            cmd.addr = ext1_reg;
            cmd.addr[dcim_pkg::EMR_DLL_DIS_BIT] = 1'b0; // [RL11]
            cmd.addr[dcim_pkg::EMR_CAL_LSB +: 3] = dcim_pkg::CAL_EXIT; // [RL23]
            next_resume = S_MR_DLLRST;
          end
          S_MR_DLLRST: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_MR};
            cmd.addr = mr_word(mode_reg, 1'b1); // [RL12]
            next_dll_cnt = 8'h00;
            next_resume = S_PREALL2;
          end
          S_MR_OP: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_MR}; // [RL22]
            cmd.addr = mr_word(mode_reg, 1'b0); // [RL13] [RL18] [RL20]
            next_resume = S_CAL_WAIT;
          end
          S_CAL_DEF, S_CAL_EXIT: begin
            cmd.ba = {1'b0, dcim_pkg::SEL_EMR1};
            cmd.addr = ext1_reg;
            cmd.addr[dcim_pkg::EMR_DLL_DIS_BIT] = 1'b0;
            cmd.addr[dcim_pkg::EMR_CAL_LSB +: 3] = (state == S_CAL_DEF) ? dcim_pkg::CAL_DEFAULT
                                                                      : dcim_pkg::CAL_EXIT; // [RL14]
            next_resume = (state == S_CAL_DEF) ? S_CAL_EXIT : S_READY;
          end
          default: ;
        endcase
      end
      S_REF: begin
        issue = 1'b1;
        cmd.enc = dcim_pkg::ENC_REF;
        next_ref_cnt = ref_cnt + 2'h1;
        next_gap = tmrd_reg;
        next_resume = (ref_cnt + 2'h1 >= 2'(dcim_pkg::INIT_REFRESH_COUNT)) ? S_MR_OP : S_REF; // [RL13]
        next_state = S_GAP;
      end
      S_CAL_WAIT: begin
        if (dll_cnt >= 8'(dcim_pkg::DLL_LOCK_CLOCKS)) next_state = S_CAL_DEF; // [RL14]
      end
      S_GAP: begin
        if (gap <= 4'h1) next_state = resume; // [RL17]
        else next_gap = gap - 4'h1;
      end
      S_READY: begin
        if (pend) begin
          next_pend = 1'b0;
          case (pend_op)
            dcim_pkg::DCIM_OP_ACT: ok = !open_bank[ba_reg]; // [RL7]
            dcim_pkg::DCIM_OP_RD, dcim_pkg::DCIM_OP_WR: ok = open_bank[ba_reg]; // [RL7]
            dcim_pkg::DCIM_OP_MRS, dcim_pkg::DCIM_OP_REF, dcim_pkg::DCIM_OP_SRE,
            dcim_pkg::DCIM_OP_PDE: ok = (open_bank == '0); // [RL7] [RL16] [RL18]
            dcim_pkg::DCIM_OP_PRE, dcim_pkg::DCIM_OP_PREALL, dcim_pkg::DCIM_OP_NOP: ok = 1'b1;
            default: ok = 1'b0;
          endcase
          if (!ok) next_err = 1'b1;
          else begin
            issue = 1'b1;
            cmd.enc = op_enc(pend_op);
            cmd.ba = ba_reg;
            cmd.addr = addr_reg[12:0];
            case (pend_op)
              dcim_pkg::DCIM_OP_ACT: next_open_bank[ba_reg] = 1'b1; // [RL5]
              dcim_pkg::DCIM_OP_PRE: begin
                cmd.addr[10] = 1'b0;
                next_open_bank[ba_reg] = 1'b0;
              end
              dcim_pkg::DCIM_OP_PREALL: begin
                cmd.addr[10] = 1'b1; // [RL6]
                next_open_bank = '0;
              end
              dcim_pkg::DCIM_OP_RD, dcim_pkg::DCIM_OP_WR: begin
                if (addr_reg[10]) next_open_bank[ba_reg] = 1'b0; // [RL6]
              end
              dcim_pkg::DCIM_OP_MRS: begin
                if (ba_reg[1:0] == dcim_pkg::SEL_MR) cmd.addr[dcim_pkg::MR_TM_BIT] = 1'b0; // [RL21]
                cmd.ba[2] = 1'b0; // [RL22]
                next_gap = tmrd_reg;
                next_resume = S_READY;
                next_state = S_GAP;
              end
              dcim_pkg::DCIM_OP_SRE, dcim_pkg::DCIM_OP_PDE: begin
                next_cke_level = 1'b0; // [RL2]
                next_state = S_PWRDN;
              end
              default: ;
            endcase
          end
        end
      end
      S_PWRDN: begin
        // Only the exit order is honoured while clock enable is low
        if (pend) begin
          next_pend = 1'b0;
          if (pend_op == dcim_pkg::DCIM_OP_EXIT) begin
            next_cke_level = 1'b1; // [RL2]
            next_gap = tmrd_reg;
            next_resume = S_READY;
            next_state = S_GAP;
          end else next_err = 1'b1;
        end
      end
      default: next_state = S_POWERUP;
    endcase

    // Loaded at the address phase so it stands through the one-cycle data phase;
    // a read right behind a write to the same register returns the older value
    if (ap_valid && !hwrite) begin
      case (haddr[7:0])
        dcim_pkg::REG_STATUS: next_hrdata = {16'h0000, open_bank, 4'h0, 1'b0, !cke_level, err,
                                             state == S_READY};
        dcim_pkg::REG_MODE: next_hrdata = {19'h00000, mode_reg};
        dcim_pkg::REG_EXT1: next_hrdata = {19'h00000, ext1_reg};
        dcim_pkg::REG_ADDR: next_hrdata = {13'h0000, ba_reg, addr_reg};
        dcim_pkg::REG_TMRD: next_hrdata = {28'h0000000, tmrd_reg};
        dcim_pkg::REG_CMD: next_hrdata = {27'h0000000, pend, pend_op};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_POWERUP;
      resume <= S_POWERUP;
      cnt <= '0;
      dll_cnt <= 8'h00;
      ref_cnt <= 2'h0;
      gap <= 4'h0;
      cke_level <= 1'b0;
      open_bank <= '0;
      mode_reg <= dcim_pkg::MODE_RESET;
      ext1_reg <= dcim_pkg::EXT1_RESET;
      tmrd_reg <= dcim_pkg::TMRD_RESET;
      addr_reg <= 16'h0000;
      ba_reg <= 3'h0;
      pend <= 1'b0;
      pend_op <= dcim_pkg::DCIM_OP_NOP;
      err <= 1'b0;
      hrdata <= 32'h00000000;
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      state <= next_state;
      resume <= next_resume;
      cnt <= next_cnt;
      dll_cnt <= next_dll_cnt;
      ref_cnt <= next_ref_cnt;
      gap <= next_gap;
      cke_level <= next_cke_level;
      open_bank <= next_open_bank;
      mode_reg <= next_mode_reg;
      ext1_reg <= next_ext1_reg;
      tmrd_reg <= next_tmrd_reg;
      addr_reg <= next_addr_reg;
      ba_reg <= next_ba_reg;
      pend <= next_pend;
      pend_op <= next_pend_op;
      err <= next_err;
      hrdata <= next_hrdata;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
    end
  end

  dcim_pin_drv u_pin_drv (
    .clk(clk),
    .sys_rst(sys_rst),
    .issue(issue),
    .cmd(cmd),
    // Next level, so clock enable moves in the same cycle as the command it qualifies
    .cke_level(next_cke_level), // [RL2]
    .pins(pins)
  );

  // Checks on the pins, the issued command and the sequencer state
  logic [3:0] enc_q;
  assign enc_q = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

  sequence mrs_seen;
    enc_q == dcim_pkg::ENC_MRS;
  endsequence

  AST_ODT_LOW: assert property (@(posedge clk) disable iff (sys_rst) !pins.odt) // [RL15]
    else $error("termination enable driven high");
  AST_CKE_LOW_POWERUP: assert property (@(posedge clk) disable iff (sys_rst)
    (state == S_POWERUP) |-> !pins.cke) // [RL15]
    else $error("clock enable high during power-up");
  AST_NOP_AFTER_CKE: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins.cke) && state == S_CKE_WAIT |-> (enc_q == dcim_pkg::ENC_NOP) [*4]) // [RL9]
    else $error("command during clock enable settle");
  AST_MRS_CKE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    mrs_seen |-> pins.cke && pins.ba[2] == 1'b0) // [RL16]
    else $error("mode write with clock enable low or bank bit two set");
  AST_MRS_GAP: assert property (@(posedge clk) disable iff (sys_rst)
    mrs_seen |=> enc_q == dcim_pkg::ENC_NOP) // [RL17]
    else $error("command right after mode write");
  AST_EMR1_DLL_ON: assert property (@(posedge clk) disable iff (sys_rst)
    mrs_seen and pins.ba[1:0] == dcim_pkg::SEL_EMR1 && resume != S_READY |-> !pins.addr[0]) // [RL11]
    else $error("loop left disabled during init");
  AST_ACT_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    issue && cmd.enc == dcim_pkg::ENC_ACT |-> !open_bank[cmd.ba]) // [RL7]
    else $error("activate to open bank");
  AST_RW_ACTIVE: assert property (@(posedge clk) disable iff (sys_rst)
    issue && (cmd.enc == dcim_pkg::ENC_RD || cmd.enc == dcim_pkg::ENC_WR) |-> open_bank[cmd.ba]) // [RL7]
    else $error("access to idle bank");
  AST_CAL_AFTER_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
    state == S_CAL_DEF |-> dll_cnt >= 8'(dcim_pkg::DLL_LOCK_CLOCKS)) // [RL14]
    else $error("calibration before loop lock");
  AST_PREALL_A10: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state) == S_PREALL1 |-> enc_q == dcim_pkg::ENC_PRE && pins.addr[10]) // [RL9]
    else $error("init precharge not all banks");
endmodule

// ===== src/dcim_pin_drv.sv
`timescale 1ns/1ps
// Registers the command onto the pins; idle cycles show no-operation
module dcim_pin_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command
  input wire logic issue,
  input wire dcim_pkg::dcim_cmd_type cmd,
  input wire logic cke_level,
  // Pins
  output dcim_pkg::dcim_pins_type pins
);
  dcim_pkg::dcim_pins_type next_pins;

  always_comb begin
    next_pins = '0;
    next_pins.cke = cke_level;
    next_pins.odt = 1'b0;
    {next_pins.cs_n, next_pins.ras_n, next_pins.cas_n, next_pins.we_n} = dcim_pkg::ENC_NOP;
    if (issue) begin
      {next_pins.cs_n, next_pins.ras_n, next_pins.cas_n, next_pins.we_n} = cmd.enc; // [RL1]
      next_pins.ba = cmd.ba;
      next_pins.addr = cmd.addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins <= {1'b0, 4'hF, 3'h0, 13'h0000, 1'b0};
    end else begin
      pins <= next_pins;
    end
  end
endmodule

// ===== src/dcim_pkg.sv
package dcim_pkg;
  // Clock rate
  localparam int CLK_PERIOD_NS = 100;
  // Power-up and init timing
  localparam int POWERUP_WAIT_US = 200;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CKE_NOP_WAIT_NS = 400;
  localparam int CKE_NOP_WAIT_CYC = (CKE_NOP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_LOCK_CLOCKS = 200;
  localparam int INIT_REFRESH_COUNT = 2;
  // Mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;
  // Extended register 1 field positions
  localparam int EMR_DLL_DIS_BIT = 0;
  localparam int EMR_CAL_LSB = 7;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  // Bank address selecting the target register
  localparam logic [1:0] SEL_MR = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [1:0] SEL_EMR2 = 2'h2;
  localparam logic [1:0] SEL_EMR3 = 2'h3;
  // Register offsets of the controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_EXT1 = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_ADDR = 8'h14;
  localparam logic [7:0] REG_TMRD = 8'h18;
  // Reset values
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam logic [12:0] EXT1_RESET = 13'h0000;
  localparam logic [3:0] TMRD_RESET = 4'h2;
  // Command strobe encodings cs_n,ras_n,cas_n,we_n
  localparam logic [3:0] ENC_ACT = 4'h3;
  localparam logic [3:0] ENC_PRE = 4'h2;
  localparam logic [3:0] ENC_WR = 4'h4;
  localparam logic [3:0] ENC_RD = 4'h5;
  localparam logic [3:0] ENC_MRS = 4'h0;
  localparam logic [3:0] ENC_REF = 4'h1;
  localparam logic [3:0] ENC_NOP = 4'h7;
  localparam logic [3:0] ENC_DESEL = 4'hF;
  // Software command codes
  typedef enum logic [3:0] {
    DCIM_OP_NOP, DCIM_OP_ACT, DCIM_OP_PRE, DCIM_OP_PREALL, DCIM_OP_RD, DCIM_OP_WR,
    DCIM_OP_REF, DCIM_OP_MRS, DCIM_OP_SRE, DCIM_OP_PDE, DCIM_OP_EXIT
  } dcim_op_type;
  // Pins toward the memory
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [12:0] addr;
    logic odt;
  } dcim_pins_type;
  // Command handed to the pin driver
  typedef struct packed {
    logic [3:0] enc;
    logic [2:0] ba;
    logic [12:0] addr;
  } dcim_cmd_type;
endpackage

// ===== tb/dcim_dram_model.sv
`timescale 1ns/1ps
// Behavioural memory: decodes the pins, tracks bank and mode state, counts misuse
module dcim_dram_model (
  // Clock
  input wire logic clk,
  // Pins from the controller
  input wire dcim_pkg::dcim_pins_type pins,
  // Observation
  output logic ev,
  output logic [3:0] ev_enc,
  output logic [3:0] burst_len,
  output logic [2:0] read_lat,
  output logic dll_on,
  output int viol
);
  logic cke_prev = 1'b0;
  logic [7:0] open_banks = 8'h00;
  // Undefined until written by the controller
  logic [12:0] mode_reg;
  logic [12:0] ext1_reg;
  logic [3:0] enc;
  assign enc = pins.cs_n ? dcim_pkg::ENC_DESEL : {1'b0, pins.ras_n, pins.cas_n, pins.we_n};
  // Deselect and no-operation both mark a clock enable edge, so report one of them
  assign ev_enc = (cke_prev != pins.cke && enc == dcim_pkg::ENC_DESEL) ? dcim_pkg::ENC_NOP : enc;
  assign ev = (cke_prev != pins.cke) ||
    (cke_prev && pins.cke && enc != dcim_pkg::ENC_NOP && enc != dcim_pkg::ENC_DESEL);
  assign burst_len = (mode_reg[2:0] == 3'h3) ? 4'h8 : 4'h4;
  assign read_lat = mode_reg[6:4];
  assign dll_on = !ext1_reg[0];
  initial viol = 0;
  always @(posedge clk) begin
    cke_prev <= pins.cke;
    if (cke_prev && pins.cke) begin
      case (enc)
        dcim_pkg::ENC_ACT: begin
          if (open_banks[pins.ba]) viol <= viol + 1;
          open_banks[pins.ba] <= 1'b1;
        end
        dcim_pkg::ENC_RD, dcim_pkg::ENC_WR: begin
          if (!open_banks[pins.ba]) viol <= viol + 1;
          if (pins.addr[10]) open_banks[pins.ba] <= 1'b0;
        end
        dcim_pkg::ENC_PRE: begin
          if (pins.addr[10]) open_banks <= 8'h00;
          else open_banks[pins.ba] <= 1'b0;
        end
        dcim_pkg::ENC_MRS, dcim_pkg::ENC_REF: begin
          if (open_banks != 8'h00) viol <= viol + 1;
          if (enc == dcim_pkg::ENC_MRS && pins.ba == 3'h0) mode_reg <= pins.addr;
          if (enc == dcim_pkg::ENC_MRS && pins.ba == 3'h1) ext1_reg <= pins.addr;
        end
        default: ;
      endcase
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int PUP = 20;
  localparam logic [12:0] MODE_A = 13'h0A43;
  localparam logic [12:0] EXT1_W = 13'h0004;
  typedef struct packed {
    logic [3:0] enc;
    logic [1:0] cke;
    logic [15:0] v;
    logic [15:0] m;
  } dcim_note_type;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, ev, dll_on;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  logic [1:0] htrans;
  logic [2:0] hsize, read_lat, b;
  logic [3:0] ev_enc, burst_len, last_enc;
  logic [12:0] rw;
  logic [9:0] col;
  dcim_pkg::dcim_pins_type pins;
  dcim_note_type exp_q[$];
  dcim_note_type nt;
  int viol, fails, n_checks, cyc, rel, n_ev, t_last, t_dll, k;
  assign hready = hreadyout;
  dcim_ctrl #(.POWERUP_CYC(PUP)) dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins));
  dcim_dram_model mem (.clk(clk), .pins(pins), .ev(ev), .ev_enc(ev_enc), .burst_len(burst_len),
    .read_lat(read_lat), .dll_on(dll_on), .viol(viol));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic note(input logic [3:0] e, input logic [1:0] c, input logic [15:0] v, input logic [15:0] m);
    exp_q.push_back('{e, c, v, m});
  endtask
  // Address phase held until hready, then data phase; read data taken at the edge ending it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, r & m, e);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic op(input dcim_pkg::dcim_op_type c, input logic [2:0] bk, input logic [12:0] a);
    logic [31:0] r;
    int n;
    bus(1'b1, dcim_pkg::REG_ADDR, {13'h0, bk, 3'h0, a}, r);
    bus(1'b1, dcim_pkg::REG_CMD, {28'h0, c}, r);
    n = 0;
    do begin
      bus(1'b0, dcim_pkg::REG_CMD, 32'h0, r);
      n++;
    end while (r[4] !== 1'b0 && n < 50);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    rel <= sys_rst ? 0 : rel + 1;
    if (!sys_rst) begin
      chk("odt", {31'h0, pins.odt}, 32'h0);
      if (ev) begin
        if (n_ev == 0) chk("powerup_wait", {31'h0, rel >= PUP}, 32'h1);
        if (n_ev == 1) chk("nop_hold", {31'h0, rel - t_last >= dcim_pkg::CKE_NOP_WAIT_CYC}, 32'h1);
        if (n_ev == 10) chk("dll_wait", {31'h0, rel - t_dll >= 200}, 32'h1);
        if (n_ev > 0 && (last_enc == dcim_pkg::ENC_MRS || last_enc == dcim_pkg::ENC_REF))
          chk("tmrd_gap", {31'h0, rel - t_last >= 3}, 32'h1);
        if (ev_enc == dcim_pkg::ENC_MRS && pins.ba == 3'h0 && pins.addr[8]) t_dll <= rel;
        t_last <= rel;
        last_enc <= ev_enc;
        n_ev <= n_ev + 1;
        if (exp_q.size() == 0) chk("extra_cmd", 32'h1, 32'h0);
        else begin
          nt = exp_q.pop_front();
          chk("enc", {28'h0, ev_enc}, {28'h0, nt.enc});
          chk("cke", {30'h0, mem.cke_prev, pins.cke}, {30'h0, nt.cke});
          chk("ba_addr", {16'h0, {pins.ba, pins.addr} & nt.m}, {16'h0, nt.v & nt.m});
        end
      end
    end
  end
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, cyc, rel, n_ev, t_last, t_dll, fails, n_checks} = '0;
    hsize = 3'h2;
    last_enc = 4'h7;
    seed = 32'hFE9A;
    sys_rst = 1'b1;
    note(4'h7, 2'h1, 16'h0, 16'h0);
    note(4'h2, 2'h3, 16'h0400, 16'h0400);
    note(4'h0, 2'h3, 16'h4000, 16'hE000);
    note(4'h0, 2'h3, 16'h6000, 16'hE000);
    note(4'h0, 2'h3, {3'h1, EXT1_W}, 16'hE381);
    note(4'h0, 2'h3, {3'h0, MODE_A | 13'h0100}, 16'hFFFF);
    note(4'h2, 2'h3, 16'h0400, 16'h0400);
    note(4'h1, 2'h3, 16'h0, 16'h0);
    note(4'h1, 2'h3, 16'h0, 16'h0);
    note(4'h0, 2'h3, {3'h0, MODE_A}, 16'hFFFF);
    note(4'h0, 2'h3, {3'h1, EXT1_W | 13'h0380}, 16'hE381);
    note(4'h0, 2'h3, {3'h1, EXT1_W}, 16'hE381);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, dcim_pkg::REG_MODE, {19'h0, MODE_A}, q);
    bus(1'b1, dcim_pkg::REG_EXT1, {19'h0, EXT1_W}, q);
    bus(1'b1, dcim_pkg::REG_TMRD, 32'h3, q);
    k = 0;
    do begin
      bus(1'b0, dcim_pkg::REG_STATUS, 32'h0, q);
      k++;
    end while (q[0] !== 1'b1 && k < 300);
    chk("burst_len", {28'h0, burst_len}, 32'h8);
    chk("read_lat", {29'h0, read_lat}, 32'h4);
    chk("dll_on", {31'h0, dll_on}, 32'h1);
    seed = xs(seed);
    b = seed[2:0];
    rw = seed[15:3];
    col = seed[25:16];
    op(dcim_pkg::DCIM_OP_NOP, b, rw);
    note(4'h3, 2'h3, {b, rw}, 16'hFFFF);
    op(dcim_pkg::DCIM_OP_ACT, b, rw);
    rchk("open_banks", dcim_pkg::REG_STATUS, 32'hFF00, {16'h0, 8'h01 << b, 8'h00});
    op(dcim_pkg::DCIM_OP_ACT, b, rw);
    rchk("act_refused", dcim_pkg::REG_STATUS, 32'h2, 32'h2);
    bus(1'b1, dcim_pkg::REG_CTRL, 32'h2, q);
    op(dcim_pkg::DCIM_OP_MRS, 3'h0, 13'h0);
    rchk("mrs_refused", dcim_pkg::REG_STATUS, 32'h2, 32'h2);
    bus(1'b1, dcim_pkg::REG_CTRL, 32'h2, q);
    rchk("err_clear", dcim_pkg::REG_STATUS, 32'h2, 32'h0);
    note(4'h4, 2'h3, {b, 3'h0, col}, 16'hE7FF);
    op(dcim_pkg::DCIM_OP_WR, b, {3'h0, col});
    note(4'h5, 2'h3, {b, 3'h1, col}, 16'hE7FF);
    op(dcim_pkg::DCIM_OP_RD, b, {3'h1, col});
    rchk("auto_pre", dcim_pkg::REG_STATUS, 32'hFF00, 32'h0);
    b = b + 3'h1;
    note(4'h3, 2'h3, {b, rw}, 16'hFFFF);
    op(dcim_pkg::DCIM_OP_ACT, b, rw);
    note(4'h2, 2'h3, 16'h0400, 16'h0400);
    op(dcim_pkg::DCIM_OP_PREALL, b, 13'h0);
    note(4'h3, 2'h3, {b, rw}, 16'hFFFF);
    op(dcim_pkg::DCIM_OP_ACT, b, rw);
    note(4'h2, 2'h3, {b, 13'h0}, 16'hE400);
    op(dcim_pkg::DCIM_OP_PRE, b, 13'h0);
    rchk("pre_close", dcim_pkg::REG_STATUS, 32'hFF00, 32'h0);
    note(4'h1, 2'h3, 16'h0, 16'h0);
    op(dcim_pkg::DCIM_OP_REF, 3'h0, 13'h0);
    bus(1'b1, dcim_pkg::REG_MODE, 32'h0632, q);
    rchk("mode_rd", dcim_pkg::REG_MODE, 32'h1FFF, 32'h0632);
    note(4'h0, 2'h3, 16'h0632, 16'hFFFF);
    op(dcim_pkg::DCIM_OP_MRS, 3'h0, 13'h0632);
    chk("burst_len4", {28'h0, burst_len}, 32'h4);
    note(4'h1, 2'h2, 16'h0, 16'h0);
    op(dcim_pkg::DCIM_OP_SRE, 3'h0, 13'h0);
    rchk("cke_low", dcim_pkg::REG_STATUS, 32'h4, 32'h4);
    note(4'h7, 2'h1, 16'h0, 16'h0);
    op(dcim_pkg::DCIM_OP_EXIT, 3'h0, 13'h0);
    note(4'h7, 2'h2, 16'h0, 16'h0);
    op(dcim_pkg::DCIM_OP_PDE, 3'h0, 13'h0);
    note(4'h7, 2'h1, 16'h0, 16'h0);
    op(dcim_pkg::DCIM_OP_EXIT, 3'h0, 13'h0);
    rchk("cke_high", dcim_pkg::REG_STATUS, 32'h4, 32'h0);
    rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    repeat (8) @(posedge clk);
    chk("pending_notes", exp_q.size(), 32'h0);
    chk("misuse", viol, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst_pins", {30'h0, pins.cke, pins.cs_n}, 32'h1);
    print_verdict();
  end
endmodule
